// file: design/ivr_ctrl.sv
`timescale 1ns/10ps
module ivr_ctrl #(
   parameter int          NUM_SRC   = ivr_pkg::NUM_SRC_DEF,
   parameter logic [53:0] SRC_LEVEL = ivr_pkg::SRC_LEVEL_DEF,
   parameter int          NUM_CS    = ivr_pkg::NUM_CS_DEF,
   parameter int          NUM_PIN   = ivr_pkg::NUM_PIN_DEF
) (
   input  wire logic                      clk,
   input  wire logic                      rst_b,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [ivr_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic [NUM_SRC-1:0]        srcEvent,
   input  wire ivr_pkg::ivr_ack_s         vectorFetchCycle,
   output ivr_pkg::ivr_vec_s              vecOut,
   output logic      [2:0]                irqLevel,
   input  wire ivr_pkg::ivr_strap_s       straps,
   output logic                           bootChipSel_b,
   output logic      [NUM_CS-1:0]         otherChipSel_b,
   output logic      [NUM_PIN-1:0]        pinOutEn,
   output logic      [NUM_PIN-1:0]        pinPullUpEn,
   output logic                           sharedDataPortIsBus,
   output ivr_pkg::ivr_mode_e             opMode
);

   // ************************************************************
   // elaboration checks
   // ************************************************************
   generate
      if (NUM_SRC < 1 || NUM_SRC > 18) begin : g_badSrc
         $error("NUM_SRC must lie in 1..18");
      end
      if (NUM_CS < 1 || NUM_PIN < 1) begin : g_badPins
         $error("NUM_CS and NUM_PIN must be at least 1");
      end
   endgenerate

   // ************************************************************
   // state
   // ************************************************************
   logic [4:0]         vecBase_reg;
   logic [4:0]         vecBase_next;
   logic               vecInit_reg;
   logic               vecInit_next;
   logic [NUM_SRC-1:0] mask_reg;
   logic [NUM_SRC-1:0] mask_next;
   logic [NUM_SRC-1:0] pending_reg;
   logic [NUM_SRC-1:0] pending_next;
   logic [31:0]        prdata_reg;
   logic [31:0]        prdata_next;
   logic               pready_reg;
   logic               pready_next;
   logic               pslverr_reg;
   logic               pslverr_next;
   logic [2:0]         level_reg;
   logic [2:0]         level_next;
   ivr_pkg::ivr_vec_s  vec_reg;
   ivr_pkg::ivr_vec_s  vec_next;
   ivr_pkg::ivr_state_e state_reg;
   ivr_pkg::ivr_state_e state_next;
   logic               wideBus_reg;
   logic               wideBus_next;
   ivr_pkg::ivr_mode_e mode_reg;
   ivr_pkg::ivr_mode_e mode_next;

   // ************************************************************
   // apb decode
   // ************************************************************
   logic [11:0] regIdx;
   logic        accessDone;
   logic        wrDone;
   logic        hitBase;
   logic        hitMask;
   logic        hitPend;
   logic        hitStat;
   logic        hitAny;

   assign regIdx     = paddr[ivr_pkg::ADDR_W-1:2];
   assign accessDone = psel & penable & pready_reg;
   assign wrDone     = accessDone & pwrite;
   assign hitBase    = (regIdx == ivr_pkg::IDX_VECBASE);
   assign hitMask    = (regIdx == ivr_pkg::IDX_MASK);
   assign hitPend    = (regIdx == ivr_pkg::IDX_PENDING);
   assign hitStat    = (regIdx == ivr_pkg::IDX_STATUS);
   assign hitAny     = hitBase | hitMask | hitPend | hitStat;

   // ************************************************************
   // priority resolution
   // ************************************************************
   logic [2:0] winLevel;
   logic [7:0] levelActive;
   logic       ackHit;

   always_comb begin
      levelActive = 8'h00;
      winLevel    = ivr_pkg::LEVEL_NONE;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (pending_reg[i] && !mask_reg[i]) begin
            levelActive[SRC_LEVEL[3*i +: 3]] = 1'b1;
         end
      end
      for (int l = 1; l < 8; l++) begin
         if (levelActive[l]) begin
            winLevel = 3'(l);
         end
      end
   end

   // acknowledge addresses the level now presented
   assign ackHit = vectorFetchCycle.cycle &&
                   (vectorFetchCycle.level == level_reg) &&
                   (level_reg != ivr_pkg::LEVEL_NONE);

   // ************************************************************
   // register file next values
   // ************************************************************
   always_comb begin
      vecBase_next = vecBase_reg;
      vecInit_next = vecInit_reg;
      mask_next    = mask_reg;
      pending_next = pending_reg;
      if (wrDone && hitBase) begin
         vecBase_next = pwdata[ivr_pkg::VEC_BASE_LSB +: ivr_pkg::VEC_BASE_W];
         vecInit_next = 1'b1;
      end
      if (wrDone && hitMask) begin
         mask_next = pwdata[NUM_SRC-1:0];
      end
      if (wrDone && hitPend) begin
         pending_next = pending_reg & ~pwdata[NUM_SRC-1:0];
      end
      // new events win over a clear in the same cycle, masked or not
      pending_next = pending_next | srcEvent;
   end

   // ************************************************************
   // apb answer: one wait state, unmapped index answers with error
   // ************************************************************
   always_comb begin
      pready_next  = psel & penable & ~pready_reg;
      pslverr_next = psel & penable & ~pready_reg & ~hitAny;
      prdata_next  = 32'h0000_0000;
      if (psel && penable && !pready_reg && !pwrite) begin
         if (hitBase) begin
            prdata_next[ivr_pkg::VEC_BASE_LSB +: ivr_pkg::VEC_BASE_W] =
               vecBase_reg;
         end
         if (hitMask) begin
            prdata_next[NUM_SRC-1:0] = mask_reg;
         end
         if (hitPend) begin
            prdata_next[NUM_SRC-1:0] = pending_reg;
         end
         if (hitStat) begin
            prdata_next[ivr_pkg::STAT_WIDTH_BIT] = wideBus_reg;
            prdata_next[ivr_pkg::STAT_MODE_LSB +: 2] = mode_reg;
            prdata_next[ivr_pkg::STAT_INIT_BIT] = vecInit_reg;
            prdata_next[ivr_pkg::STAT_LEVEL_LSB +: 3] = level_reg;
         end
      end
   end

   // ************************************************************
   // request level and vector drive
   // ************************************************************
   always_comb begin
      // hold the presented code steady through its acknowledge
      level_next = ackHit ? level_reg : winLevel;
      vec_next   = '0;
      if (ackHit) begin
         vec_next.oe = 1'b1;
         if (vecInit_reg) begin
            vec_next.data = {vecBase_reg, level_reg};
         end else begin
            vec_next.data = ivr_pkg::VEC_UNINIT;
         end
      end
   end

   // ************************************************************
   // strap capture at reset release
   // ************************************************************
   always_comb begin
      state_next   = state_reg;
      wideBus_next = wideBus_reg;
      mode_next    = mode_reg;
      unique case (state_reg)
         ivr_pkg::ST_CAPTURE: begin
            wideBus_next = straps.widthStrap;
            if (!straps.emuIrqStrap && !straps.emuBreakStrap) begin
               mode_next = ivr_pkg::MODE_BOOTSTRAP;
            end else if (!straps.emuBreakStrap || !straps.hiZStrap) begin
               mode_next = ivr_pkg::MODE_EMULATION;
            end else begin
               mode_next = ivr_pkg::MODE_NORMAL;
            end
            state_next = ivr_pkg::ST_RUN;
         end
         ivr_pkg::ST_RUN: begin
            state_next = ivr_pkg::ST_RUN;
         end
         default: begin
            state_next = ivr_pkg::ST_CAPTURE;
         end
      endcase
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         vecBase_reg <= ivr_pkg::VECBASE_RST;
         vecInit_reg <= 1'b0;
         mask_reg    <= ivr_pkg::MASK_RST[NUM_SRC-1:0];
         pending_reg <= ivr_pkg::PENDING_RST[NUM_SRC-1:0];
         prdata_reg  <= 32'h0000_0000;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         level_reg   <= ivr_pkg::LEVEL_NONE;
         vec_reg     <= '0;
         state_reg   <= ivr_pkg::ST_CAPTURE;
         wideBus_reg <= 1'b0;
         mode_reg    <= ivr_pkg::MODE_NORMAL;
      end else begin
         vecBase_reg <= vecBase_next;
         vecInit_reg <= vecInit_next;
         mask_reg    <= mask_next;
         pending_reg <= pending_next;
         prdata_reg  <= prdata_next;
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
         level_reg   <= level_next;
         vec_reg     <= vec_next;
         state_reg   <= state_next;
         wideBus_reg <= wideBus_next;
         mode_reg    <= mode_next;
      end
   end

   // ************************************************************
   // pin defaults, chip selects and outputs
   // ************************************************************
   logic               bootCs_reg;
   logic [NUM_CS-1:0]  otherCs_reg;
   logic [NUM_PIN-1:0] pinOe_reg;
   logic [NUM_PIN-1:0] pinPu_reg;
   logic               portBus_reg;

   // no reset output exists; the reset pin is only ever an input
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         bootCs_reg  <= 1'b0;
         otherCs_reg <= '1;
         pinOe_reg   <= '0;
         pinPu_reg   <= '1;
         portBus_reg <= 1'b0;
      end else begin
         bootCs_reg  <= 1'b0;
         otherCs_reg <= '1;
         pinOe_reg   <= '0;
         pinPu_reg   <= {NUM_PIN{~wideBus_reg}};
         portBus_reg <= wideBus_reg;
      end
   end

   assign prdata              = prdata_reg;
   assign pready              = pready_reg;
   assign pslverr             = pslverr_reg;
   assign vecOut              = vec_reg;
   assign irqLevel            = level_reg;
   assign bootChipSel_b       = bootCs_reg;
   assign otherChipSel_b      = otherCs_reg;
   assign pinOutEn            = pinOe_reg;
   assign pinPullUpEn         = pinPu_reg;
   assign sharedDataPortIsBus = portBus_reg;
   assign opMode              = mode_reg;

endmodule

// file: design/ivr_pkg.sv
package ivr_pkg;

   // ************************************************************
   // apb register map: index of each register, byte address = 4*idx
   // ************************************************************
   localparam int          ADDR_W      = 14;
   localparam logic [11:0] IDX_VECBASE = 12'h300;
   localparam logic [11:0] IDX_MASK    = 12'h304;
   localparam logic [11:0] IDX_PENDING = 12'h30c;
   localparam logic [11:0] IDX_STATUS  = 12'h310;

   // ************************************************************
   // field layout and reset values
   // ************************************************************
   localparam int          VEC_BASE_LSB   = 3;
   localparam int          VEC_BASE_W     = 5;
   localparam int          LEVEL_W        = 3;
   localparam logic [7:0]  VEC_UNINIT     = 8'h0f;
   localparam logic [4:0]  VECBASE_RST    = 5'h00;
   localparam logic [31:0] MASK_RST       = 32'h0000_0000;
   localparam logic [31:0] PENDING_RST    = 32'h0000_0000;
   localparam logic [2:0]  LEVEL_NONE     = 3'h0;
   localparam int          STAT_WIDTH_BIT = 0;
   localparam int          STAT_MODE_LSB  = 1;
   localparam int          STAT_INIT_BIT  = 3;
   localparam int          STAT_LEVEL_LSB = 4;

   // ************************************************************
   // source count and level of each source (index 0 last)
   // ************************************************************
   localparam int          NUM_SRC_DEF = 18;
   localparam logic [53:0] SRC_LEVEL_DEF = {
      3'h1, 3'h2, 3'h3,
      3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4,
      3'h5, 3'h6, 3'h6, 3'h6, 3'h7};
   localparam int          NUM_CS_DEF  = 7;
   localparam int          NUM_PIN_DEF = 8;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {
      MODE_NORMAL    = 2'h0,
      MODE_EMULATION = 2'h1,
      MODE_BOOTSTRAP = 2'h3
   } ivr_mode_e;

   typedef enum logic [1:0] {
      ST_CAPTURE = 2'h0,
      ST_RUN     = 2'h1
   } ivr_state_e;

   typedef struct packed {
      logic       cycle;
      logic [2:0] level;
   } ivr_ack_s;

   typedef struct packed {
      logic       oe;
      logic [7:0] data;
   } ivr_vec_s;

   typedef struct packed {
      logic widthStrap;
      logic emuIrqStrap;
      logic emuBreakStrap;
      logic hiZStrap;
   } ivr_strap_s;

endpackage

// file: testbench/ivr_chk.sv
`timescale 1ns/10ps
module ivr_chk #(
   parameter int NUM_CS  = 7,
   parameter int NUM_PIN = 8
) (
   input wire logic                clk,
   input wire logic                rst_b,
   input wire ivr_pkg::ivr_ack_s   vectorFetchCycle,
   input wire ivr_pkg::ivr_vec_s   vecOut,
   input wire logic [2:0]          irqLevel,
   input wire ivr_pkg::ivr_strap_s straps,
   input wire logic                bootChipSel_b,
   input wire logic [NUM_CS-1:0]   otherChipSel_b,
   input wire logic [NUM_PIN-1:0]  pinOutEn,
   input wire logic [NUM_PIN-1:0]  pinPullUpEn,
   input wire logic                sharedDataPortIsBus,
   input wire ivr_pkg::ivr_mode_e  opMode
);
   // ****
   // port checks
   // ****
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   logic hit;
   assign hit = vectorFetchCycle.cycle && irqLevel != 3'h0
                && vectorFetchCycle.level == irqLevel;
   function automatic ivr_pkg::ivr_mode_e mode_of(ivr_pkg::ivr_strap_s s);
      if (!s.emuIrqStrap && !s.emuBreakStrap)
         return ivr_pkg::MODE_BOOTSTRAP;
      if (!s.emuBreakStrap || !s.hiZStrap)
         return ivr_pkg::MODE_EMULATION;
      return ivr_pkg::MODE_NORMAL;
   endfunction
   property p_boot_cs;
      !bootChipSel_b && &otherChipSel_b;
   endproperty
   property p_pin_in;
      pinOutEn == '0;
   endproperty
   property p_pullup;
      pinPullUpEn == {NUM_PIN{!sharedDataPortIsBus}};
   endproperty
   property p_width;
      $rose(rst_b) |-> ##2 sharedDataPortIsBus == $past(straps.widthStrap, 2);
   endproperty
   property p_mode;
      $rose(rst_b) |-> ##2 opMode == mode_of($past(straps, 2));
   endproperty
   property p_ack;
      hit |=> vecOut.oe;
   endproperty
   property p_cause;
      vecOut.oe |-> $past(hit);
   endproperty
   property p_vec;
      vecOut.oe |-> vecOut.data == ivr_pkg::VEC_UNINIT
                    || vecOut.data[2:0] == $past(irqLevel);
   endproperty
   property p_hold;
      hit |=> $stable(irqLevel);
   endproperty
   a_boot_cs: assert property (p_boot_cs)
      else $error("chip select levels wrong");
   a_pin_in: assert property (p_pin_in)
      else $error("pin driven as output");
   a_pullup: assert property (p_pullup)
      else $error("pull-up state wrong");
   a_width: assert property (p_width)
      else $error("width strap not captured");
   a_mode: assert property (p_mode)
      else $error("mode decode wrong");
   a_ack: assert property (p_ack)
      else $error("vector not driven");
   a_cause: assert property (p_cause)
      else $error("vector driven without matching cycle");
   a_vec: assert property (p_vec)
      else $error("vector low bits wrong");
   a_hold: assert property (p_hold)
      else $error("level moved during acknowledge");
   c_uninit: cover property (vecOut.oe && vecOut.data == ivr_pkg::VEC_UNINIT);
   c_level: cover property (vecOut.oe && vecOut.data[7:3] != 5'h00);
   c_boot: cover property (opMode == ivr_pkg::MODE_BOOTSTRAP);
endmodule

bind ivr_ctrl ivr_chk #(.NUM_CS(NUM_CS), .NUM_PIN(NUM_PIN)) ivr_chk_i (
   .clk(clk), .rst_b(rst_b), .vectorFetchCycle(vectorFetchCycle),
   .vecOut(vecOut), .irqLevel(irqLevel), .straps(straps),
   .bootChipSel_b(bootChipSel_b), .otherChipSel_b(otherChipSel_b),
   .pinOutEn(pinOutEn), .pinPullUpEn(pinPullUpEn),
   .sharedDataPortIsBus(sharedDataPortIsBus), .opMode(opMode)
);

// file: testbench/ivr_core_model.sv
`timescale 1ns/10ps
module ivr_core_model (
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              ackReq,
   input  wire logic [2:0]        lvlFlip,
   input  wire logic [1:0]        slow,
   input  wire logic [2:0]        irqLevel,
   input  wire ivr_pkg::ivr_vec_s vecOut,
   output ivr_pkg::ivr_ack_s      vectorFetchCycle,
   output logic      [7:0]        vecGot,
   output logic      [7:0]        vecCnt
);
   // ****
   // core acknowledge cycles
   // ****
   logic [2:0] lvl;
   logic [2:0] priMask;
   int         bootCnt;
   initial begin
      vectorFetchCycle = 4'h5;
      vecGot = 8'h00;
      vecCnt = 8'h00;
      priMask = 3'h7;
      bootCnt = 4;
      forever begin
         @(posedge clk);
         if (!rst_b) begin
            priMask = 3'h7;
            bootCnt = 4;
         end else if (bootCnt != 0) begin
            bootCnt--;
         end else if (ackReq) begin
            priMask = 3'h0;
         end
         if (rst_b && bootCnt == 0 && ackReq && irqLevel != 3'h0 &&
             (irqLevel == 3'h7 || irqLevel > priMask)) begin
            repeat (slow) @(posedge clk);
            lvl = irqLevel ^ lvlFlip;
            vectorFetchCycle <= {1'b1, lvl};
            for (int i = 0; i < 4 && vecOut.oe !== 1'b1; i++) begin
               @(posedge clk);
            end
            vecGot <= vecOut.oe ? vecOut.data : 8'h18;
            vecCnt <= vecCnt + 8'h01;
            vectorFetchCycle <= {1'b0, ~lvl};
            while (ackReq) @(posedge clk);
         end
      end
   end
endmodule

// file: testbench/irq_vector_and_reset_config_tb_top.sv
`timescale 1ns/10ps
module irq_vector_and_reset_config_tb_top;
   // ****
   // bench
   // ****
   logic                clk = 1'b0;
   logic                rst_b = 1'b0;
   logic                psel = 1'b0;
   logic                penable = 1'b0;
   logic                pwrite = 1'b0;
   logic [13:0]         paddr = 14'h0;
   logic [31:0]         pwdata = 32'h0;
   logic [31:0]         prdata, r;
   logic                pready, pslverr, e, bootCs_b, isBus;
   logic [17:0]         srcEvent = 18'h0;
   ivr_pkg::ivr_ack_s   vfc;
   ivr_pkg::ivr_vec_s   vecOut;
   logic [2:0]          irqLevel, lv;
   logic [2:0]          lvlFlip = 3'h0;
   logic [1:0]          slow = 2'h0;
   logic                ackReq = 1'b0;
   logic [7:0]          vecGot, vecCnt, pinOutEn, pullUp;
   logic [6:0]          otherCs_b;
   ivr_pkg::ivr_strap_s straps = 4'hf;
   ivr_pkg::ivr_mode_e  opMode;
   int                  num_errors = 0;
   int                  checked = 0;

   ivr_ctrl ivr_ctrl_i (
      .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .srcEvent(srcEvent),
      .vectorFetchCycle(vfc), .vecOut(vecOut), .irqLevel(irqLevel),
      .straps(straps), .bootChipSel_b(bootCs_b), .otherChipSel_b(otherCs_b),
      .pinOutEn(pinOutEn), .pinPullUpEn(pullUp),
      .sharedDataPortIsBus(isBus), .opMode(opMode)
   );
   ivr_core_model ivr_core_model_i (
      .clk(clk), .rst_b(rst_b), .ackReq(ackReq), .lvlFlip(lvlFlip),
      .slow(slow), .irqLevel(irqLevel), .vecOut(vecOut),
      .vectorFetchCycle(vfc), .vecGot(vecGot), .vecCnt(vecCnt)
   );

   task automatic summarize;
      if (num_errors == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] idx,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk);
      end
      if (n >= 20) begin
         num_errors++;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [11:0] idx, input logic [32:0] exp);
      apb(1'b0, idx, 32'h0);
      chk({e, r}, exp);
   endtask
   task automatic wr(input logic [11:0] idx, input logic [31:0] d,
                     input logic err);
      apb(1'b1, idx, d);
      chk({32'h0, e}, {32'h0, err});
   endtask
   task automatic ev(input logic [17:0] m);
      srcEvent <= m;
      @(posedge clk);
      srcEvent <= 18'h0;
      repeat (3) @(posedge clk);
   endtask
   task automatic ack(input logic [7:0] exp);
      logic [7:0] c0;
      int n;
      c0 = vecCnt;
      n = 0;
      ackReq <= 1'b1;
      while (vecCnt === c0 && n < 40) begin
         n++;
         @(posedge clk);
      end
      ackReq <= 1'b0;
      if (n >= 40) begin
         num_errors++;
      end
      chk(vecGot, exp);
   endtask
   task automatic do_reset(input ivr_pkg::ivr_strap_s s);
      straps <= s;
      rst_b <= 1'b0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
   endtask

   initial begin
      forever #12.5 clk = ~clk;
   end
   initial begin
      #125000;
      num_errors++;
      summarize;
   end
   initial begin
      ivr_pkg::ivr_strap_s st [3];
      ivr_pkg::ivr_mode_e  md [3];
      st = '{4'hf, 4'h9, 4'h6};
      md = '{ivr_pkg::MODE_NORMAL, ivr_pkg::MODE_BOOTSTRAP,
             ivr_pkg::MODE_EMULATION};
      for (int k = 0; k < 3; k++) begin
         do_reset(st[k]);
         chk(opMode, md[k]);
         chk(isBus, st[k].widthStrap);
         chk(pullUp, {8{~st[k].widthStrap}});
         chk({bootCs_b, otherCs_b, pinOutEn}, 16'h7f00);
      end
      rd(ivr_pkg::IDX_MASK, 33'h0);
      rd(ivr_pkg::IDX_PENDING, 33'h0);
      rd(ivr_pkg::IDX_STATUS, 33'h2);
      ev(18'h1);
      chk(irqLevel, 3'h7);
      ack(ivr_pkg::VEC_UNINIT);
      wr(ivr_pkg::IDX_PENDING, 32'h3ffff, 1'b0);
      wr(ivr_pkg::IDX_VECBASE, 32'h47, 1'b0);
      rd(ivr_pkg::IDX_VECBASE, 33'h40);
      rd(ivr_pkg::IDX_STATUS, 33'ha);
      for (int i = 0; i < 18; i++) begin
         lv = (i == 0) ? 3'h7 : (i < 4) ? 3'h6 : (i == 4) ? 3'h5 :
              (i < 15) ? 3'h4 : 3'(18 - i);
         slow <= 2'(i);
         ev(18'h1 << i);
         chk(irqLevel, lv);
         rd(ivr_pkg::IDX_PENDING, 33'h1 << i);
         ack({5'h08, lv});
         wr(ivr_pkg::IDX_PENDING, 32'h3ffff, 1'b0);
      end
      ev(18'h20010);
      chk(irqLevel, 3'h5);
      wr(ivr_pkg::IDX_MASK, 32'h10, 1'b0);
      repeat (2) @(posedge clk);
      chk(irqLevel, 3'h1);
      rd(ivr_pkg::IDX_PENDING, 33'h20010);
      lvlFlip <= 3'h2;
      ack(8'h18);
      lvlFlip <= 3'h0;
      wr(ivr_pkg::IDX_MASK, 32'h0, 1'b0);
      repeat (2) @(posedge clk);
      ack(8'h45);
      wr(ivr_pkg::IDX_STATUS, 32'h0, 1'b0);
      rd(ivr_pkg::IDX_STATUS, 33'h5a);
      wr(ivr_pkg::IDX_PENDING, 32'h3ffff, 1'b0);
      wr(ivr_pkg::IDX_MASK, 32'h2, 1'b0);
      ev(18'h2);
      chk(irqLevel, 3'h0);
      rd(ivr_pkg::IDX_PENDING, 33'h2);
      rd(12'h3ff, {1'b1, 32'h0});
      wr(12'h3ff, 32'h1, 1'b1);
      summarize;
   end
endmodule
